// ===== verilog/bclb_cmd_core.sv
// boot-mode interpreter for lifecycle query and boundary setting commands
`timescale 1ns/10ps
module bclb_cmd_core
  import bclb_pkg::*;
#(
  parameter int BUF_DEPTH = 16,
  parameter int BUF_AW    = 4
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,              // freezes all state when low
  input  wire logic        rx_valid,            // received byte strobe
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,            // response byte offered
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,            // link takes the byte
  input  wire logic [7:0]  lifecycle_state,     // current lifecycle code
  input  wire logic        boundary_allowed,    // boundary write legal now
  output logic             flash_req,           // boundary write to flash
  output logic      [15:0] code_secure_size_no_callable,
  output logic      [15:0] code_secure_size_total,
  output logic      [15:0] data_secure_size,
  output logic      [15:0] sram_secure_size_no_callable,
  output logic      [15:0] sram_secure_size_total,
  input  wire logic        flash_done,          // write finished pulse
  input  wire logic        flash_error,         // qualifies flash_done
  input  wire logic [31:0] flash_status,        // flash status word
  output logic             busy                 // not waiting for a command
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bclb_state_t  state_reg;          // interpreter state
  logic [15:0]  len_reg;            // received length field
  logic [15:0]  body_cnt_reg;       // body bytes taken so far
  logic [7:0]   cmd_reg;            // command byte
  logic         etx_bad_reg;        // end byte was wrong
  logic [3:0]   ld_cnt_reg;         // buffer unload counter
  logic [79:0]  params_reg;         // boundary sizes, first byte on top
  logic [7:0]   sts_reg;            // status of the reply
  logic         data_rsp_reg;       // reply is the lifecycle data form
  logic [31:0]  detail_reg;         // status_detail field of the reply
  logic [7:0]   lc_reg;             // lifecycle code captured for reply
  logic [3:0]   tx_idx_reg;         // index of byte on tx_data
  logic [7:0]   rx_sum;             // running receive sum
  logic [7:0]   tx_sum;             // running transmit sum
  logic [7:0]   rd_data;            // buffer read data
  logic         rx_take;            // byte accepted by receiver
  logic         tx_fire;            // byte handed to the link
  logic [3:0]   tx_sum_pos;         // checksum position of this reply
  logic [15:0]  body_idx;           // body byte index minus one
  logic [7:0]   next_byte;          // byte following the current one
  logic [15:0]  f_cnc;              // size fields split from params
  logic [15:0]  f_ctot;
  logic [15:0]  f_srnc;
  logic [15:0]  f_srtot;
  logic [7:0]   verdict_sts;        // status formed while in CHECK
  logic         verdict_data;       // good query, data reply form

  assign rx_take  = rx_valid && (state_reg inside {ST_IDLE, ST_LEN_H, ST_LEN_L,
                                                   ST_BODY, ST_SUM, ST_END});
  assign tx_valid = (state_reg == ST_SEND);
  assign tx_fire  = tx_valid && tx_ready;
  assign busy     = (state_reg != ST_IDLE);
  assign body_idx = body_cnt_reg - 16'h0001;
  assign f_cnc    = params_reg[79:64];
  assign f_ctot   = params_reg[63:48];
  assign f_srnc   = params_reg[31:16];
  assign f_srtot  = params_reg[15:0];
  assign tx_sum_pos = data_rsp_reg ? TX_SUM_DATA : TX_SUM_STATUS;

  // ----------------------------------------------------------------
  // checksum accumulators and payload buffer
  // ----------------------------------------------------------------
  // receive sum covers both length bytes through the checksum byte
  bclb_sum_acc u_rx_sum (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clear  (state_reg == ST_IDLE),
    .add    (rx_take && (state_reg inside {ST_LEN_H, ST_LEN_L, ST_BODY, ST_SUM})),
    .data   (rx_data),
    .sum    (rx_sum)
  );

  // transmit sum covers length bytes through the last payload byte
  bclb_sum_acc u_tx_sum (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clear  (state_reg != ST_SEND),
    .add    (tx_fire && (tx_idx_reg != 4'h0)),
    .data   (tx_data),
    .sum    (tx_sum)
  );

  // parameter bytes after the command byte land here
  bclb_pkt_buf #(
    .DEPTH (BUF_DEPTH),
    .AW    (BUF_AW)
  ) u_buf (
    .clock   (clock),
    .clk_en  (clk_en),
    .wr_en   (rx_take && (state_reg == ST_BODY) && (body_cnt_reg != 16'h0000)
              && (body_idx < 16'(BUF_DEPTH))),
    .wr_addr (body_idx[BUF_AW-1:0]),
    .wr_data (rx_data),
    .rd_addr (ld_cnt_reg[BUF_AW-1:0]),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // interpreter state machine
  // ----------------------------------------------------------------
  // bytes arriving outside the receive states are dropped; the host
  // must wait for the reply before sending more
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (rx_take && (rx_data == CMD_START)) begin
            state_reg <= ST_LEN_H;
          end
        end
        ST_LEN_H: begin
          if (rx_take) begin
            state_reg <= ST_LEN_L;
          end
        end
        ST_LEN_L: begin
          // zero length has no body; cmd_reg stays zero, so the packet is dropped at the end byte with no reply
          if (rx_take) begin
            state_reg <= ({len_reg[15:8], rx_data} == 16'h0000) ? ST_SUM : ST_BODY;
          end
        end
        ST_BODY: begin
          if (rx_take && (body_cnt_reg == len_reg - 16'h0001)) begin
            state_reg <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (rx_take) begin
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          // other commands belong to other interpreters
          if (rx_take) begin
            if ((cmd_reg == CMD_LC_QUERY) || (cmd_reg == CMD_BOUNDARY)) begin
              state_reg <= ST_LOAD;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_LOAD: begin
          if (ld_cnt_reg == PARAM_BYTES) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // flash is reached only when every check passed; the live
          // verdict is used because the stored one lands at this edge
          if (!verdict_data && (verdict_sts == STS_OK)) begin
            state_reg <= ST_FLASH;
          end else begin
            state_reg <= ST_SEND;
          end
        end
        ST_FLASH: begin
          if (flash_done) begin
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_fire && (tx_idx_reg == tx_sum_pos + 4'h1)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive capture
  // ----------------------------------------------------------------
  // length, command and end-byte status of the packet in flight
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      len_reg      <= 16'h0000;
      body_cnt_reg <= 16'h0000;
      cmd_reg      <= 8'h00;
      etx_bad_reg  <= 1'b0;
    end else if (clk_en && rx_take) begin
      if (state_reg == ST_LEN_H) begin
        len_reg[15:8] <= rx_data;
        body_cnt_reg  <= 16'h0000;
        cmd_reg       <= 8'h00;
      end else if (state_reg == ST_LEN_L) begin
        len_reg[7:0] <= rx_data;
      end else if (state_reg == ST_BODY) begin
        body_cnt_reg <= body_cnt_reg + 16'h0001;
        if (body_cnt_reg == 16'h0000) begin
          cmd_reg <= rx_data;
        end
      end else if (state_reg == ST_END) begin
        etx_bad_reg <= (rx_data != PKT_END);
      end
    end
  end

  // ----------------------------------------------------------------
  // parameter unload from the buffer
  // ----------------------------------------------------------------
  // read data trail the address by one cycle, so shifting starts late
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ld_cnt_reg <= 4'h0;
      params_reg <= 80'h0;
    end else if (clk_en) begin
      if (state_reg != ST_LOAD) begin
        ld_cnt_reg <= 4'h0;
      end else if (ld_cnt_reg != PARAM_BYTES) begin
        ld_cnt_reg <= ld_cnt_reg + 4'h1;
      end
      if ((state_reg == ST_LOAD) && (ld_cnt_reg != 4'h0)) begin
        params_reg <= {params_reg[71:0], rd_data};
      end
    end
  end

  // ----------------------------------------------------------------
  // packet analysis and verdict
  // ----------------------------------------------------------------
  // the chain order is the reporting priority; only the first hit counts
  always_comb begin
    verdict_sts  = STS_OK;
    verdict_data = 1'b0;
    if (etx_bad_reg) begin
      verdict_sts = STS_PACKET;
    end else if (rx_sum != 8'h00) begin
      verdict_sts = STS_CHECKSUM;
    end else if ((len_reg < LEN_MIN) || (len_reg > LEN_MAX)) begin
      verdict_sts = STS_PACKET;
    end else if ((cmd_reg == CMD_LC_QUERY) && (len_reg != LEN_LC_QUERY)) begin
      verdict_sts = STS_PACKET;
    end else if ((cmd_reg == CMD_BOUNDARY) && (len_reg != LEN_BOUNDARY)) begin
      verdict_sts = STS_PACKET;
    end else if (cmd_reg == CMD_LC_QUERY) begin
      verdict_data = 1'b1;
    end else if (!boundary_allowed) begin
      verdict_sts = STS_ACCEPT;
    end else if (f_cnc > f_ctot) begin
      verdict_sts = STS_PARAM;
    end else if (f_srnc > f_srtot) begin
      verdict_sts = STS_PARAM;
    end
  end

  // verdict kept for the reply; a flash failure overrides the status
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sts_reg      <= STS_OK;
      data_rsp_reg <= 1'b0;
      lc_reg       <= 8'h00;
    end else if (clk_en && (state_reg == ST_CHECK)) begin
      sts_reg      <= verdict_sts;
      data_rsp_reg <= verdict_data;
      lc_reg       <= lifecycle_state;
    end else if (clk_en && (state_reg == ST_FLASH) && flash_done && flash_error) begin
      sts_reg <= STS_FLASH;
    end
  end

  // detail field: unused filler unless flash reports a failure
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      detail_reg <= {4{UNUSED_BYTE}};
    end else if (clk_en) begin
      if (state_reg == ST_CHECK) begin
        detail_reg <= {4{UNUSED_BYTE}};
      end else if ((state_reg == ST_FLASH) && flash_done && flash_error) begin
        detail_reg <= flash_status;
      end
    end
  end

  // ----------------------------------------------------------------
  // flash write request
  // ----------------------------------------------------------------
  // only the stored copy changes; the live partition is read from
  // flash at the next reset, so nothing here drives it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flash_req                    <= 1'b0;
      code_secure_size_no_callable <= 16'h0000;
      code_secure_size_total       <= 16'h0000;
      data_secure_size             <= 16'h0000;
      sram_secure_size_no_callable <= 16'h0000;
      sram_secure_size_total       <= 16'h0000;
    end else if (clk_en) begin
      if ((state_reg == ST_CHECK) && (state_reg != ST_FLASH)) begin
        flash_req <= 1'b0;
      end
      if ((state_reg == ST_FLASH) && flash_done) begin
        flash_req <= 1'b0;
      end else if (state_reg == ST_FLASH) begin
        flash_req                    <= 1'b1;
        code_secure_size_no_callable <= f_cnc;
        code_secure_size_total       <= f_ctot & CODE_ALIGN_MASK;
        data_secure_size             <= params_reg[47:32];
        sram_secure_size_no_callable <= f_srnc;
        sram_secure_size_total       <= f_srtot & SRAM_ALIGN_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // response byte selection
  // ----------------------------------------------------------------
  // the checksum byte makes the sum from length to checksum zero
  always_comb begin
    next_byte = UNUSED_BYTE;
    if (tx_idx_reg + 4'h1 == tx_sum_pos) begin
      next_byte = 8'h00 - (tx_sum + tx_data);
    end else if (tx_idx_reg == tx_sum_pos) begin
      next_byte = PKT_END;
    end else if (tx_idx_reg + 4'h1 == TX_POS_LNH) begin
      next_byte = 8'h00;
    end else if (tx_idx_reg + 4'h1 == TX_POS_LNL) begin
      next_byte = data_rsp_reg ? LEN_LC_RESP : LEN_STATUS_RESP;
    end else if (tx_idx_reg + 4'h1 == TX_POS_RES) begin
      // failure replies carry the command code with its top bit set
      if (data_rsp_reg || (sts_reg == STS_OK)) begin
        next_byte = cmd_reg;
      end else begin
        next_byte = cmd_reg | RSP_ERR_FLAG;
      end
    end else if (tx_idx_reg + 4'h1 == TX_POS_STS) begin
      next_byte = data_rsp_reg ? lc_reg : sts_reg;
    end else if (tx_idx_reg + 4'h1 < TX_POS_ADR) begin
      case (tx_idx_reg[1:0])
        2'h0: next_byte = detail_reg[31:24];
        2'h1: next_byte = detail_reg[23:16];
        2'h2: next_byte = detail_reg[15:8];
        default: next_byte = detail_reg[7:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit registers
  // ----------------------------------------------------------------
  // tx_data is preloaded with the start byte before the reply begins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_idx_reg <= 4'h0;
      tx_data    <= RSP_START;
    end else if (clk_en) begin
      if (state_reg != ST_SEND) begin
        tx_idx_reg <= 4'h0;
        tx_data    <= RSP_START;
      end else if (tx_fire) begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
        tx_data    <= next_byte;
      end
    end
  end
endmodule : bclb_cmd_core

// ===== shared/bclb_pkg.sv
// constants for the boot lifecycle and boundary command interpreter
package bclb_pkg;
  // ----------------------------------------------------------------
  // framing bytes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_START       = 8'h01;  // start of command packet
  localparam logic [7:0]  PKT_END         = 8'h03;  // end-of-text byte
  localparam logic [7:0]  RSP_START       = 8'h81;  // response_start byte
  localparam logic [7:0]  RSP_ERR_FLAG    = 8'h80;  // or-ed into response_code on error
  localparam logic [7:0]  UNUSED_BYTE     = 8'hff;  // unused-code filler byte
  // ----------------------------------------------------------------
  // commands and lengths
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_LC_QUERY    = 8'h2c;  // lifecycle-state query
  localparam logic [7:0]  CMD_BOUNDARY    = 8'h4e;  // boundary setting write
  localparam logic [15:0] LEN_LC_QUERY    = 16'h0001;
  localparam logic [15:0] LEN_BOUNDARY    = 16'h000b;
  localparam logic [15:0] LEN_MIN         = 16'h0001;  // generic format bounds
  localparam logic [15:0] LEN_MAX         = 16'h0100;
  localparam logic [7:0]  LEN_LC_RESP     = 8'h02;
  localparam logic [7:0]  LEN_STATUS_RESP = 8'h0a;
  // ----------------------------------------------------------------
  // status codes (error codes other than flash are arbitrary values)
  // ----------------------------------------------------------------
  localparam logic [7:0]  STS_OK          = 8'h00;
  localparam logic [7:0]  STS_FLASH       = 8'he5;
  localparam logic [7:0]  STS_PACKET      = 8'hc1;
  localparam logic [7:0]  STS_CHECKSUM    = 8'hc2;
  localparam logic [7:0]  STS_ACCEPT      = 8'hc3;
  localparam logic [7:0]  STS_PARAM       = 8'hc4;
  // ----------------------------------------------------------------
  // boundary fields
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_ALIGN_MASK = 16'hffe0;  // 32 KB granules
  localparam logic [15:0] SRAM_ALIGN_MASK = 16'hfff8;  // 8 KB granules
  localparam logic [3:0]  PARAM_BYTES     = 4'ha;      // five 2-byte sizes
  // ----------------------------------------------------------------
  // response byte positions
  // ----------------------------------------------------------------
  localparam logic [3:0]  TX_POS_LNH      = 4'h1;
  localparam logic [3:0]  TX_POS_LNL      = 4'h2;
  localparam logic [3:0]  TX_POS_RES      = 4'h3;
  localparam logic [3:0]  TX_POS_STS      = 4'h4;
  localparam logic [3:0]  TX_POS_ADR      = 4'h9;
  localparam logic [3:0]  TX_SUM_DATA     = 4'h5;
  localparam logic [3:0]  TX_SUM_STATUS   = 4'hd;

  // one-hot interpreter states
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_LEN_H = 10'h002,
    ST_LEN_L = 10'h004,
    ST_BODY  = 10'h008,
    ST_SUM   = 10'h010,
    ST_END   = 10'h020,
    ST_LOAD  = 10'h040,
    ST_CHECK = 10'h080,
    ST_FLASH = 10'h100,
    ST_SEND  = 10'h200
  } bclb_state_t;
endpackage : bclb_pkg

// ===== verilog/bclb_sum_acc.sv
// modulo-256 byte sum accumulator
`timescale 1ns/10ps
module bclb_sum_acc (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       clear,   // restart the sum
  input  wire logic       add,     // fold data into the sum
  input  wire logic [7:0] data,
  output logic      [7:0] sum
);
  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  // clear wins so a new packet never inherits the old total
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sum <= 8'h00;
    end else if (clk_en) begin
      if (clear) begin
        sum <= 8'h00;
      end else if (add) begin
        sum <= sum + data;
      end
    end
  end
endmodule : bclb_sum_acc

// ===== verilog/bclb_pkt_buf.sv
// small payload buffer with registered read data
`timescale 1ns/10ps
module bclb_pkt_buf #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          clock,
  input  wire logic          clk_en,
  input  wire logic          wr_en,    // write strobe
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,  // read is one cycle late
  output logic      [7:0]    rd_data
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [DEPTH];  // payload bytes, no reset needed

  // write port
  always_ff @(posedge clock) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clock) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : bclb_pkt_buf

// ===== tb/bclb_chk_sva.sv
// port assertions for the command interpreter
`timescale 1ns/10ps
module bclb_chk
  import bclb_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        busy,
  input wire logic        flash_req,
  input wire logic        flash_done,
  input wire logic        boundary_allowed,
  input wire logic [15:0] code_secure_size_total,
  input wire logic [15:0] sram_secure_size_total
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a reply opens on the rising valid; a write ends on done
  sequence reply_open_s; $rose(tx_valid); endsequence
  sequence flash_end_s; flash_req && flash_done; endsequence
  reply_start_a: assert property (reply_open_s |-> tx_data == RSP_START)
    else $error("reply did not open with start byte");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved before it was taken");
  flash_gate_a: assert property ($rose(flash_req) |-> boundary_allowed)
    else $error("flash write started while refused");
  size_align_a: assert property (flash_req |->
    code_secure_size_total[4:0] == 5'h00 && sram_secure_size_total[2:0] == 3'h0)
    else $error("stored totals not rounded down");
  flash_hold_a: assert property (flash_req && !flash_done |=> flash_req &&
    $stable(code_secure_size_total))
    else $error("flash write dropped or sizes moved");
  flash_reply_a: assert property (flash_end_s |=> !flash_req && tx_valid)
    else $error("no reply right after flash done");
  idle_quiet_a: assert property (!busy |-> !tx_valid && !flash_req)
    else $error("activity while waiting for a command");
  reply_done_a: assert property ($fell(tx_valid) |-> !busy)
    else $error("not back to waiting after reply");
  reset_quiet_a: assert property ($rose(rst_n) |-> !busy && !tx_valid && !flash_req)
    else $error("outputs active out of reset");
endmodule : bclb_chk

// ===== tb/bclb_host_model.sv
// host programmer model: sends packets, collects replies
`timescale 1ns/10ps
module bclb_host_model (
  input wire logic       clock,
  output logic           rx_valid,
  output logic     [7:0] rx_data,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  output logic           tx_ready
);
  logic slow;  // drops tx_ready every other cycle when high
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    slow = 1'b0;
  end
  // one whole packet, byte per cycle; idle data inverted so it never looks held
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = b[i];
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : send
  // take the reply until its length field is used up; ready low outside
  task automatic recv(output logic [7:0] r[$]);
    r = {};
    for (int w = 0; w < 400 && (r.size() < 3 || r.size() < r[2] + 5); w++) begin
      @(negedge clock);
      tx_ready = slow ? w[0] : 1'b1;
      if (tx_valid === 1'b1 && tx_ready) r.push_back(tx_data);
    end
    @(negedge clock);
    tx_ready = 1'b0;
  endtask : recv
endmodule : bclb_host_model

// ===== tb/boot_lifecycle_boundary_cmds_bench.sv
// self-checking bench for the command interpreter
`timescale 1ns/10ps
module boot_lifecycle_boundary_cmds_bench;
  import bclb_pkg::*;
  typedef logic [7:0] bclb_bq_t[$];
  logic        clock = 1'b0, rst_n = 1'b0, boundary_allowed = 1'b0, seen = 1'b0;
  logic        rx_valid, tx_valid, tx_ready, busy, flash_req;
  logic        flash_done = 1'b0, flash_error = 1'b0;
  logic [7:0]  rx_data, tx_data, lifecycle_state = 8'h5a;
  logic [15:0] cnc, ctot, dsz, snc, stot;
  logic [31:0] flash_status = 32'h0;
  int          num_errors = 0, n_compared = 0;
  bclb_bq_t    r;
  bclb_cmd_core dut (.clock, .rst_n, .clk_en(1'b1), .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready, .lifecycle_state, .boundary_allowed, .flash_req,
    .code_secure_size_no_callable(cnc), .code_secure_size_total(ctot),
    .data_secure_size(dsz), .sram_secure_size_no_callable(snc),
    .sram_secure_size_total(stot), .flash_done, .flash_error, .flash_status, .busy);
  bclb_host_model host (.clock, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  always #20 clock = ~clock;
  // sticky mark of any flash write, cleared before each error-test packet
  always @(posedge clock) if (flash_req === 1'b1) seen <= 1'b1;
  task automatic results;
    $display("compares %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic fail(input logic [31:0] g, e);
    num_errors++;
    $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
  endtask : fail
  task automatic chk_v(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) fail(g, e);
  endtask : chk_v
  task automatic chk_q(input bclb_bq_t g, e);
    n_compared++;
    if (g.size() != e.size()) fail(g.size(), e.size());
    else foreach (e[i]) if (g[i] !== e[i]) fail(g[i], e[i]);
  endtask : chk_q
  // modulo-256 sum from the length bytes on, negated, then the end byte
  function automatic bclb_bq_t sum_end(input bclb_bq_t q);
    logic [7:0] s = 8'h00;
    foreach (q[i]) if (i > 0) s += q[i];
    return {q, 8'h00 - s, PKT_END};
  endfunction : sum_end
  function automatic bclb_bq_t st_rsp(input logic [7:0] res, sts, input logic [31:0] d);
    return sum_end({RSP_START, 8'h00, 8'h0a, res, sts, d[31:24], d[23:16], d[15:8], d[7:0],
      8'hff, 8'hff, 8'hff, 8'hff});
  endfunction : st_rsp
  // boundary packet: code totals 0x0127, data 0x0004, sram total 0x004f
  function automatic bclb_bq_t bpkt(input logic [15:0] len, a, b);
    bclb_bq_t q = '{CMD_START, len[15:8], len[7:0], 8'h4e, a[15:8], a[7:0], 8'h01, 8'h27,
      8'h00, 8'h04, b[15:8], b[7:0], 8'h00, 8'h4f};
    if (len != 16'h000b) void'(q.pop_back());
    return sum_end(q);
  endfunction : bpkt
  task automatic run(input bclb_bq_t p, e);
    host.send(p);
    host.recv(r);
    chk_q(r, e);
  endtask : run
  // noise before a query, then the literal query with a stalling host
  task automatic t_query;
    host.slow = 1'b1;
    host.send('{8'h00, 8'h55, 8'h03});
    run('{8'h01, 8'h00, 8'h01, 8'h2c, 8'hd3, 8'h03},
      '{8'h81, 8'h00, 8'h02, 8'h2c, 8'h5a, 8'h78, 8'h03});
    host.slow = 1'b0;
    $display("test query done");
  endtask : t_query
  // bad end, bad sum, both, command length, format length
  task automatic t_qerr;
    bclb_bq_t p;
    logic [7:0] sts [5] = '{8'hc1, 8'hc2, 8'hc1, 8'hc1, 8'hc1};
    for (int k = 0; k < 5; k++) begin
      p = sum_end('{8'h01, 8'h00, 8'h01, 8'h2c});
      if (k == 0 || k == 2) p[5] = 8'h04;
      if (k == 1 || k == 2) p[4] = 8'hd4;
      if (k == 3) p = sum_end('{8'h01, 8'h00, 8'h02, 8'h2c, 8'h00});
      if (k == 4) begin
        p = '{8'h01, 8'h01, 8'h01, 8'h2c};
        repeat (256) p.push_back(8'h00);
        p = sum_end(p);
      end
      seen = 1'b0;
      run(p, st_rsp(8'hac, sts[k], 32'hffffffff));
      chk_v(seen, 1'b0);
    end
    $display("test query errors done");
  endtask : t_qerr
  // refused, code over, sram over, refused and over, short length
  task automatic t_berr;
    logic ok [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [15:0] a [5] = '{16'h0127, 16'h0128, 16'h0127, 16'h0128, 16'h0127};
    logic [15:0] b [5] = '{16'h0008, 16'h0008, 16'h0050, 16'h0008, 16'h0008};
    logic [7:0] sts [5] = '{8'hc3, 8'hc4, 8'hc4, 8'hc3, 8'hc1};
    for (int k = 0; k < 5; k++) begin
      boundary_allowed = ok[k];
      seen = 1'b0;
      run(bpkt(k == 4 ? 16'h000a : 16'h000b, a[k], b[k]),
        st_rsp(8'hce, sts[k], 32'hffffffff));
      chk_v(seen, 1'b0);
    end
    $display("test boundary errors done");
  endtask : t_berr
  // a good write, then one that the flash controller fails
  task automatic t_bok;
    boundary_allowed = 1'b1;
    for (int k = 0; k < 2; k++) begin
      host.send(bpkt(16'h000b, 16'h0127, 16'h0008));
      for (int w = 0; w < 40 && flash_req !== 1'b1; w++) @(negedge clock);
      chk_v({cnc, ctot}, 32'h01270120);
      chk_v({dsz[7:0], snc, stot[7:0]}, 32'h04000848);
      repeat (3) @(negedge clock);
      flash_done = 1'b1;
      flash_error = k[0];
      flash_status = 32'h0120a000;
      @(negedge clock);
      flash_done = 1'b0;
      host.recv(r);
      if (k == 0) chk_q(r, st_rsp(8'h4e, 8'h00, 32'hffffffff));
      else chk_q(r, st_rsp(8'hce, 8'he5, 32'h0120a000));
    end
    $display("test boundary write done");
  endtask : t_bok
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    t_query;
    t_qerr;
    t_berr;
    t_bok;
    results;
  end
  // watchdog: the run needs under a thousand cycles of the 20000 allowed
  initial begin
    #(40 * 20000);
    num_errors++;
    results;
  end
endmodule : boot_lifecycle_boundary_cmds_bench
bind bclb_cmd_core bclb_chk chk (.clock, .rst_n, .tx_valid, .tx_data, .tx_ready, .busy,
  .flash_req, .flash_done, .boundary_allowed, .code_secure_size_total,
  .sram_secure_size_total);
